// >>> src/video_out_pkg.sv
// constants, field layouts and carrier types of the video output unit
// assumes a 32-bit avalon-mm register bus with byte addresses
`default_nettype none

package video_out_pkg;

  // register byte offsets
  localparam logic [4:0] CTRL_OFS   = 5'h00;
  localparam logic [4:0] FRAME_OFS  = 5'h04;
  localparam logic [4:0] LINE_OFS   = 5'h08;
  localparam logic [4:0] FIELD_OFS  = 5'h0c;
  localparam logic [4:0] VACT_OFS   = 5'h10;
  localparam logic [4:0] SLVDLY_OFS = 5'h14;
  localparam logic [4:0] MSGLEN_OFS = 5'h18;
  localparam logic [4:0] STATUS_OFS = 5'h1c;

  // reset values (525-line geometry)
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
  localparam logic [31:0] FRAME_RESET  = 32'h0002_020d;
  localparam logic [31:0] LINE_RESET   = 32'h0114_06b4;
  localparam logic [31:0] FIELD_RESET  = 32'h0000_010a;
  localparam logic [31:0] VACT_RESET   = 32'h011b_0014;
  localparam logic [31:0] SLVDLY_RESET = 32'h0000_0000;
  localparam logic [31:0] MSGLEN_RESET = 32'h0000_0010;
  localparam logic [31:0] CTRL_MASK    = 32'h0000_0f7f;

  // status bit positions
  localparam int ST_DRAINED = 0;
  localparam int ST_BWERR   = 1;
  localparam int ST_LOCKED  = 2;
  localparam int ST_FIELD   = 3;

  // modes
  localparam logic [3:0] MODE_LAST_VIDEO = 4'h6;
  localparam logic [3:0] MODE_STREAM     = 4'h8;
  localparam logic [3:0] MODE_MESSAGE    = 4'h9;

  // stream bytes
  localparam logic [7:0]  BLANK_CHROMA = 8'h80;
  localparam logic [7:0]  BLANK_LUMA   = 8'h10;
  localparam logic [7:0]  PREAMBLE_FF  = 8'hff;
  localparam logic [7:0]  PREAMBLE_00  = 8'h00;
  localparam logic [11:0] LINE_FIRST   = 12'h001;
  localparam logic [11:0] SYNC_LEN     = 12'h004;

  // chroma kernel taps (-1, 5, 13, -1) / 16
  localparam logic [12:0] TAP_INNER_B = 13'h0005;
  localparam logic [12:0] TAP_INNER_C = 13'h000d;
  localparam logic [12:0] TAP_ROUND   = 13'h0008;
  localparam int          TAP_SHIFT   = 4;

  typedef struct packed {
    logic [19:0] spare;
    logic [3:0]  mode;
    logic        spare2;
    logic        runEn;
    logic        syncStreaming;
    logic        framePol;
    logic        genlockEn;
    logic        fieldSync;
    logic        extEnable;
    logic        syncMaster;
  } ctrl_type;

  typedef struct packed {
    logic [7:0] u;
    logic [7:0] y0;
    logic [7:0] v;
    logic [7:0] y1;
  } pix_group_type;

  typedef enum logic [3:0] {
    RAW_IDLE  = 4'b0001,
    RAW_START = 4'b0010,
    RAW_SEND  = 4'b0100,
    RAW_END   = 4'b1000
  } raw_state_type;

endpackage

`default_nettype wire

// >>> src/video_out_sync_and_transfer.sv
// video output sync, genlock and raw byte transfer unit
// assumes video clock pin slower than sys_clk/2; pixel source sits outside
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`default_nettype none

module video_out_sync_and_transfer (
  input  wire logic                        sys_clk,
  input  wire logic                        reset_n,
  input  wire logic [4:0]                  avsAddress,
  input  wire logic                        avsRead,
  input  wire logic                        avsWrite,
  input  wire logic [3:0]                  avsByteEnable,
  input  wire logic [31:0]                 avsWriteData,
  output logic      [31:0]                 avsReadData,
  output logic                             avsWaitRequest,
  input  wire logic                        videoOutClock,
  input  wire logic                        frameStrobeIn,
  output logic                             frameStrobeOut,
  output logic                             frameStrobeOeN,
  output logic                             lineStrobeOut,
  output logic      [7:0]                  videoByteBus,
  input  wire video_out_pkg::pix_group_type pixIn,
  output logic                             pixReq,
  output logic                             chromaLineStep,
  input  wire logic [7:0]                  byteIn,
  input  wire logic                        byteValid,
  output logic                             byteReady,
  output logic                             msgDonePulse
);
  import video_out_pkg::*;

  // byte-enable merge for register writes
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
    input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) res[i*8 +: 8] = wd[i*8 +: 8];
    end
    return res;
  endfunction

  // four-tap chroma kernel, clamped to a byte
  function automatic logic [7:0] coSite(input logic [7:0] a, b, c, d);
    logic [12:0] pos;
    logic [12:0] neg;
    logic [12:0] diff;
    pos  = 13'(b) * TAP_INNER_B + 13'(c) * TAP_INNER_C + TAP_ROUND;
    neg  = 13'(a) + 13'(d);
    diff = (pos > neg) ? ((pos - neg) >> TAP_SHIFT) : 13'h0000;
    return (diff > 13'h00ff) ? 8'hff : diff[7:0];
  endfunction

  // timing reference code byte with protection bits
  function automatic logic [7:0] syncCode(input logic f, v, h);
    return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
  endfunction

  logic          rstMeta_r, rstSync_r;
  logic          vclkMeta_r, vclkSync_r, vclkPrev_r, vTick;
  logic          fsMeta_r, fsSync_r, fsPrev_r, activeEdge;
  logic          busAck_r;
  ctrl_type      ctrl_r;
  logic [31:0]   frame_r, line_r, field_r, vact_r, slvdly_r, msglen_r;
  logic          drained_r, bwErr_r, locked_r, pending_r;
  logic [3:0]    resyncCnt_r;
  logic [15:0]   dlyCnt_r, msgCnt_r;
  logic [11:0]   pixCnt_r, lineCnt_r, pixNxt, lineNxt;
  logic [11:0]   frameLen, framePreset, lineLen, savPos, f2Start;
  logic          rawMode, streamMode, refresh, genlockOn, fire;
  logic          fieldTwo, vBlank, activePix, hwStop, wrHit, bwFault;
  logic          interspersed, doubled, halfLines, grpOdd_r;
  logic [1:0]    phase;
  logic [7:0]    uHist_r [4];
  logic [7:0]    vHist_r [4];
  pix_group_type grp_r;
  raw_state_type rawState_r;
  logic [31:0]   readWord;

  // reset released through two flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  // pin synchronisers; the second and third flops feed edge detection, the first never does
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      vclkMeta_r <= 1'b0;
      vclkSync_r <= 1'b0;
      vclkPrev_r <= 1'b0;
      fsMeta_r   <= 1'b0;
      fsSync_r   <= 1'b0;
      fsPrev_r   <= 1'b0;
    end else begin
      vclkMeta_r <= videoOutClock;
      vclkSync_r <= vclkMeta_r;
      vclkPrev_r <= vclkSync_r;
      fsMeta_r   <= frameStrobeIn;
      fsSync_r   <= fsMeta_r;
      fsPrev_r   <= fsSync_r;
    end
  end

  assign vTick = vclkSync_r & ~vclkPrev_r;

  // field decode of the geometry words
  assign frameLen    = frame_r[11:0];
  assign framePreset = frame_r[27:16];
  assign lineLen     = line_r[11:0];
  assign savPos      = line_r[27:16];
  assign f2Start     = field_r[11:0];

  // mode decode
  assign refresh      = ctrl_r.mode <= MODE_LAST_VIDEO;
  assign streamMode   = ctrl_r.mode == MODE_STREAM;
  assign rawMode      = streamMode | (ctrl_r.mode == MODE_MESSAGE);
  assign interspersed = refresh & (ctrl_r.mode[1:0] != 2'b00);
  assign doubled      = refresh & ctrl_r.mode[2];
  assign halfLines    = refresh & (ctrl_r.mode[1:0] == 2'b10);
  assign genlockOn    = ~ctrl_r.syncMaster & ctrl_r.extEnable
                        & ctrl_r.genlockEn;
  assign activeEdge   = genlockOn & (ctrl_r.framePol ? (fsSync_r & ~fsPrev_r)
                        : (~fsSync_r & fsPrev_r));
  assign fire         = pending_r & vTick & (dlyCnt_r == 16'h0000);

  // avalon slave: one wait state, then the request completes
  assign avsWaitRequest = (avsRead | avsWrite) & ~busAck_r;
  assign wrHit          = avsWrite & busAck_r;
  assign bwFault        = streamMode & vTick & (rawState_r == RAW_SEND)
                          & ctrl_r.runEn & ~byteValid;
  assign hwStop         = (vTick & (rawState_r == RAW_END)) | bwFault;

  always_comb begin
    case (avsAddress)
      CTRL_OFS:   readWord = 32'(ctrl_r);
      FRAME_OFS:  readWord = frame_r;
      LINE_OFS:   readWord = line_r;
      FIELD_OFS:  readWord = field_r;
      VACT_OFS:   readWord = vact_r;
      SLVDLY_OFS: readWord = slvdly_r;
      MSGLEN_OFS: readWord = msglen_r;
      STATUS_OFS: readWord = {4'h0, lineCnt_r, 8'h00, resyncCnt_r,
                              fieldTwo, locked_r, bwErr_r, drained_r};
      default:    readWord = 32'h0000_0000;
    endcase
  end

  // bus handshake and read data
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      busAck_r    <= 1'b0;
      avsReadData <= 32'h0000_0000;
    end else begin
      busAck_r <= (avsRead | avsWrite) & ~busAck_r;
      if (avsRead & ~busAck_r) avsReadData <= readWord;
    end
  end

  // software registers; a write of run enable beats the hardware stop
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      ctrl_r   <= ctrl_type'(CTRL_RESET);
      frame_r  <= FRAME_RESET;
      line_r   <= LINE_RESET;
      field_r  <= FIELD_RESET;
      vact_r   <= VACT_RESET;
      slvdly_r <= SLVDLY_RESET;
      msglen_r <= MSGLEN_RESET;
    end else begin
      if (hwStop) ctrl_r.runEn <= 1'b0;
      if (wrHit) begin
        case (avsAddress)
          CTRL_OFS:   ctrl_r <= ctrl_type'(mergeBytes(32'(ctrl_r),
                        avsWriteData, avsByteEnable) & CTRL_MASK);
          FRAME_OFS:  frame_r  <= mergeBytes(frame_r, avsWriteData,
                                             avsByteEnable);
          LINE_OFS:   line_r   <= mergeBytes(line_r, avsWriteData,
                                             avsByteEnable);
          FIELD_OFS:  field_r  <= mergeBytes(field_r, avsWriteData,
                                             avsByteEnable);
          VACT_OFS:   vact_r   <= mergeBytes(vact_r, avsWriteData,
                                             avsByteEnable);
          SLVDLY_OFS: slvdly_r <= mergeBytes(slvdly_r, avsWriteData,
                                             avsByteEnable);
          MSGLEN_OFS: msglen_r <= mergeBytes(msglen_r, avsWriteData,
                                             avsByteEnable);
          default: ;
        endcase
      end
    end
  end

  // sticky status, write one to clear; a same-cycle set wins
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      drained_r <= 1'b0;
      bwErr_r   <= 1'b0;
    end else begin
      drained_r <= (vTick & (rawState_r == RAW_END)) | (drained_r & ~(wrHit
        & (avsAddress == STATUS_OFS) & avsByteEnable[0]
        & avsWriteData[ST_DRAINED]));
      bwErr_r   <= bwFault | (bwErr_r & ~(wrHit
        & (avsAddress == STATUS_OFS) & avsByteEnable[0]
        & avsWriteData[ST_BWERR]));
    end
  end

  // genlock edge delay and lock tracking
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      pending_r   <= 1'b0;
      dlyCnt_r    <= 16'h0000;
      locked_r    <= 1'b0;
      resyncCnt_r <= 4'h0;
    end else if (!genlockOn) begin
      pending_r <= 1'b0;
      locked_r  <= 1'b0;
    end else begin
      if (activeEdge) begin
        pending_r <= 1'b1;
        dlyCnt_r  <= slvdly_r[15:0];
      end else if (pending_r & vTick) begin
        if (dlyCnt_r == 16'h0000) pending_r <= 1'b0;
        else dlyCnt_r <= dlyCnt_r - 16'h0001;
      end
      if (fire) begin
        locked_r <= 1'b1;
        // agreeing edge: the counters would land here anyway
        if (!locked_r || pixNxt != 12'h000 || lineNxt != framePreset)
          resyncCnt_r <= resyncCnt_r + 4'h1;
      end
    end
  end

  // next counter positions
  always_comb begin
    pixNxt  = pixCnt_r + 12'h001;
    lineNxt = lineCnt_r;
    if (pixCnt_r >= lineLen - 12'h001) begin
      pixNxt  = 12'h000;
      lineNxt = (lineCnt_r >= frameLen) ? LINE_FIRST
                : lineCnt_r + 12'h001;
    end
  end

  // frame counters free-run until a delayed edge reloads them
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      pixCnt_r  <= 12'h000;
      lineCnt_r <= LINE_FIRST;
    end else if (vTick) begin
      if (fire) begin
        pixCnt_r  <= 12'h000;
        lineCnt_r <= framePreset;
      end else begin
        pixCnt_r  <= pixNxt;
        lineCnt_r <= lineNxt;
      end
    end
  end

  assign fieldTwo  = lineCnt_r >= f2Start;
  assign vBlank    = fieldTwo ? (lineCnt_r < vact_r[27:16])
                     : (lineCnt_r < vact_r[11:0]);
  assign activePix = (pixCnt_r >= savPos) & ~vBlank;
  assign phase     = 2'(pixCnt_r - savPos);

  // pixel groups, with chroma history for the co-siting kernel
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      grp_r    <= '0;
      grpOdd_r <= 1'b0;
      pixReq   <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        uHist_r[i] <= 8'h00;
        vHist_r[i] <= 8'h00;
      end
    end else begin
      pixReq <= 1'b0;
      if (vTick & refresh & ~vBlank & ((pixCnt_r == savPos - 12'h001)
          | (activePix & (phase == 2'b11)))) begin
        grpOdd_r <= doubled & ~grpOdd_r & (pixCnt_r != savPos - 12'h001);
        // 2x width repeats a group; every second fetch after the first is skipped
        if (!(doubled & ~grpOdd_r & (pixCnt_r != savPos - 12'h001))) begin
          pixReq <= 1'b1;
          for (int i = 1; i < 4; i++) begin
            uHist_r[i] <= uHist_r[i-1];
            vHist_r[i] <= vHist_r[i-1];
          end
          uHist_r[0] <= pixIn.u;
          vHist_r[0] <= pixIn.v;
          grp_r.y0   <= pixIn.y0;
          grp_r.y1   <= pixIn.y1;
          grp_r.u    <= interspersed ? coSite(uHist_r[2], uHist_r[1],
                        uHist_r[0], pixIn.u) : pixIn.u;
          grp_r.v    <= interspersed ? coSite(vHist_r[2], vHist_r[1],
                        vHist_r[0], pixIn.v) : pixIn.v;
        end
      end
    end
  end

  // chroma plane line step: every line, or every second for 4:2:0
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) chromaLineStep <= 1'b0;
    else chromaLineStep <= vTick & refresh & (pixNxt == 12'h000)
                           & (~halfLines | lineCnt_r[0]);
  end

  // raw transfer sequencer
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      rawState_r <= RAW_IDLE;
      msgCnt_r   <= 16'h0000;
    end else if (vTick) begin
      case (rawState_r)
        RAW_IDLE: begin
          msgCnt_r <= 16'h0000;
          if (rawMode & ctrl_r.runEn) rawState_r <= RAW_START;
        end
        RAW_START: rawState_r <= RAW_SEND;
        RAW_SEND: begin
          if (!rawMode | !ctrl_r.runEn | bwFault) rawState_r <= RAW_IDLE;
          else if (!streamMode & byteValid) begin
            msgCnt_r <= msgCnt_r + 16'h0001;
            if (msgCnt_r + 16'h0001 >= msglen_r[15:0])
              rawState_r <= RAW_END;
          end
        end
        RAW_END: rawState_r <= RAW_IDLE;
        default: rawState_r <= RAW_IDLE;
      endcase
    end
  end

  assign byteReady = vTick & (rawState_r == RAW_SEND) & rawMode
                     & ctrl_r.runEn;

  // pins and byte bus change on a video clock rising edge, except the frame pin enable and the done pulse
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      lineStrobeOut  <= 1'b1;
      frameStrobeOut <= 1'b0;
      frameStrobeOeN <= 1'b0;
      videoByteBus   <= BLANK_CHROMA;
      msgDonePulse   <= 1'b0;
    end else begin
      frameStrobeOeN <= genlockOn & ~rawMode;
      msgDonePulse   <= vTick & (rawState_r == RAW_END);
      if (vTick & rawMode) begin
        lineStrobeOut <= rawState_r == RAW_START;
        if (streamMode)
          frameStrobeOut <= ctrl_r.extEnable & ctrl_r.syncStreaming
            & (rawState_r == RAW_SEND) & ctrl_r.runEn & byteValid;
        else
          frameStrobeOut <= rawState_r == RAW_END;
        if (byteReady & byteValid) videoByteBus <= byteIn;
      end else if (vTick) begin
        lineStrobeOut <= ~ctrl_r.syncMaster | (pixCnt_r >= savPos);
        if (ctrl_r.syncMaster & (pixCnt_r == 12'h000))
          frameStrobeOut <= (ctrl_r.extEnable & ctrl_r.fieldSync)
            ? fieldTwo : (lineCnt_r == LINE_FIRST);
        if (pixCnt_r < SYNC_LEN)
          videoByteBus <= (pixCnt_r == 12'h000) ? PREAMBLE_FF
            : (pixCnt_r == 12'h003) ? syncCode(fieldTwo, vBlank, 1'b1)
            : PREAMBLE_00;
        else if (pixCnt_r >= savPos - SYNC_LEN && pixCnt_r < savPos)
          videoByteBus <= (pixCnt_r == savPos - SYNC_LEN) ? PREAMBLE_FF
            : (pixCnt_r == savPos - 12'h001)
            ? syncCode(fieldTwo, vBlank, 1'b0) : PREAMBLE_00;
        else if (activePix)
          case (phase)
            2'b00:   videoByteBus <= grp_r.u;
            2'b01:   videoByteBus <= grp_r.y0;
            2'b10:   videoByteBus <= grp_r.v;
            default: videoByteBus <= grp_r.y1;
          endcase
        else
          videoByteBus <= pixCnt_r[0] ? BLANK_LUMA : BLANK_CHROMA;
      end
    end
  end

  property p_hblank_low;
    @(posedge sys_clk) disable iff (!rstSync_r)
    (vTick & ~rawMode & ctrl_r.syncMaster & (pixCnt_r < savPos))
      |=> !lineStrobeOut;
  endproperty
  a_hblank_low: assert property (p_hblank_low)
    else $error("line pin not low in blanking");

  property p_field_pin;
    @(posedge sys_clk) disable iff (!rstSync_r)
    (vTick & ~rawMode & ctrl_r.syncMaster & ctrl_r.extEnable
      & ctrl_r.fieldSync & (pixCnt_r == 12'h000))
      |=> (frameStrobeOut == $past(fieldTwo));
  endproperty
  a_field_pin: assert property (p_field_pin)
    else $error("frame pin does not show field");

  property p_genlock_oe;
    @(posedge sys_clk) disable iff (!rstSync_r)
    (genlockOn & ~rawMode) [*2] |-> frameStrobeOeN;
  endproperty
  a_genlock_oe: assert property (p_genlock_oe)
    else $error("frame pin driven during genlock");

  property p_edge_delay;
    @(posedge sys_clk) disable iff (!rstSync_r)
    (activeEdge & genlockOn)
      |=> (pending_r && dlyCnt_r == $past(slvdly_r[15:0]));
  endproperty
  a_edge_delay: assert property (p_edge_delay)
    else $error("edge delay not loaded");

  property p_preset_load;
    @(posedge sys_clk) disable iff (!rstSync_r)
    fire |=> (lineCnt_r == $past(framePreset)) && (pixCnt_r == 12'h000);
  endproperty
  a_preset_load: assert property (p_preset_load)
    else $error("line counter not preset");

  property p_stream_pulse;
    @(posedge sys_clk) disable iff (!rstSync_r)
    (vTick & rawMode) |=> (lineStrobeOut == ($past(rawState_r) == RAW_START));
  endproperty
  a_stream_pulse: assert property (p_stream_pulse)
    else $error("start pulse missing");

  property p_bw_drop;
    @(posedge sys_clk) disable iff (!rstSync_r)
    bwFault |=> (!frameStrobeOut && bwErr_r && !ctrl_r.runEn);
  endproperty
  a_bw_drop: assert property (p_bw_drop)
    else $error("valid held after bandwidth error");

  property p_msg_end;
    @(posedge sys_clk) disable iff (!rstSync_r)
    (vTick & (rawState_r == RAW_END) & ~wrHit)
      |=> (frameStrobeOut && drained_r && msgDonePulse && !ctrl_r.runEn
           && rawState_r == RAW_IDLE);
  endproperty
  a_msg_end: assert property (p_msg_end)
    else $error("message end not signalled");

  property p_blank_code;
    @(posedge sys_clk) disable iff (!rstSync_r)
    (vTick & refresh & ~activePix & (pixCnt_r >= SYNC_LEN)
      & (pixCnt_r < savPos - SYNC_LEN))
      |=> (videoByteBus == ($past(pixCnt_r[0]) ? BLANK_LUMA : BLANK_CHROMA));
  endproperty
  a_blank_code: assert property (p_blank_code)
    else $error("wrong blanking byte");

endmodule

`default_nettype wire

// >>> test/video_out_partner.sv
// partner model: external encoder frame pin and raw byte source
// assumes dut pins change on sys_clk; the link clock pin runs free
`default_nettype none
module video_out_partner (
  input  wire logic       sys_clk,
  input  wire logic       srcOn,
  input  wire logic       frameStrobeOut,
  input  wire logic       frameStrobeOeN,
  input  wire logic       byteReady,
  output logic            videoOutClock,
  output logic            frameStrobeIn,
  output logic      [7:0] byteIn,
  output logic            byteValid
);
  timeunit 1ns;
  timeprecision 1ns;
  // 80 ns link clock, offset so its edges always fall 2 ns after a sys_clk rising edge
  initial begin
    videoOutClock = 1'b0;
    #7;
    forever #40 videoOutClock = ~videoOutClock;
  end
  // encoder frame pulse, 120 link clocks a frame, high in the first half;
  // the encoder drives the pin only while the dut has released it
  logic [7:0] extCnt = 8'h00;
  always @(posedge videoOutClock)
    extCnt <= (extCnt == 8'h77) ? 8'h00 : extCnt + 8'h01;
  assign frameStrobeIn = frameStrobeOeN ? (extCnt < 8'h3c) : frameStrobeOut;
  // byte source; stops on srcOn low to force an underrun
  initial begin
    byteIn = 8'h00;
    byteValid = 1'b0;
    forever begin
      @(posedge sys_clk);
      byteValid <= srcOn;
      if (byteReady && byteValid) byteIn <= byteIn + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> test/video_out_sync_and_transfer_test.sv
// self-checking bench: resets, raw transfers, field pin and genlock
// assumes the partner model supplies the link clock and the byte source
`default_nettype none
module video_out_sync_and_transfer_test;
  import video_out_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, reset_n, avsRead, avsWrite, srcOn;
  logic [4:0]  avsAddress;
  logic [31:0] avsWriteData, avsReadData, q, qOld;
  pix_group_type pixIn;
  logic        avsWaitRequest, videoOutClock, frameStrobeIn, frameStrobeOut;
  logic        frameStrobeOeN, lineStrobeOut, pixReq, chromaLineStep;
  logic [7:0]  videoByteBus, byteIn;
  logic        byteValid, byteReady, msgDonePulse;
  int          errorCnt = 0, compares = 0, taken = 0, i;
  logic [4:0]  rowAddr [6] = '{CTRL_OFS, FRAME_OFS, LINE_OFS, SLVDLY_OFS,
                               MSGLEN_OFS, 5'h02};
  logic [31:0] rowExp [6] = '{CTRL_RESET, FRAME_RESET, LINE_RESET,
                              SLVDLY_RESET, MSGLEN_RESET, 32'h0};
  video_out_sync_and_transfer u_video_out_sync_and_transfer (.sys_clk,
    .reset_n, .avsAddress, .avsRead, .avsWrite, .avsByteEnable(4'hf),
    .avsWriteData, .avsReadData, .avsWaitRequest, .videoOutClock,
    .frameStrobeIn, .frameStrobeOut, .frameStrobeOeN, .lineStrobeOut,
    .videoByteBus, .pixIn, .pixReq, .chromaLineStep, .byteIn,
    .byteValid, .byteReady, .msgDonePulse);
  video_out_partner u_video_out_partner (.sys_clk, .srcOn, .frameStrobeOut,
    .frameStrobeOeN, .byteReady, .videoOutClock, .frameStrobeIn, .byteIn,
    .byteValid);
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;
  // bytes handed over, counted independently of the dut's own length count
  always @(posedge sys_clk) if (byteReady && byteValid) taken <= taken + 1;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errorCnt++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // avalon cycle: request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWriteData <= d;
    do @(posedge sys_clk); while (avsWaitRequest !== 1'b0);
    r = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task end_of_test;
    if (errorCnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // watchdog well past the longest expected wait
  initial begin
    #200000;
    errorCnt++;
    end_of_test;
  end
  initial begin
    {reset_n, avsRead, avsWrite, srcOn} = 4'h0;
    avsAddress = 5'h00;
    avsWriteData = 32'h0;
    pixIn = pix_group_type'(32'h445a_667b);
    repeat (8) @(posedge sys_clk);
    chk(lineStrobeOut, 1'b1);
    chk(videoByteBus, BLANK_CHROMA);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (i = 0; i < 6; i++) begin
      bus(1'b0, rowAddr[i], 32'h0, q);
      chk(q, rowExp[i]);
    end
    // message of four bytes, then the unit must stop by itself
    bus(1'b1, MSGLEN_OFS, 32'h4, q);
    srcOn <= 1'b1;
    i = taken;
    bus(1'b1, CTRL_OFS, {20'h0, MODE_MESSAGE, 8'h43}, q);
    for (int n = 0; n < 3000 && msgDonePulse !== 1'b1; n++) @(posedge sys_clk);
    chk(msgDonePulse, 1'b1);
    chk(taken - i, 4);
    bus(1'b0, STATUS_OFS, 32'h0, q);
    chk(q[ST_DRAINED], 1'b1);
    bus(1'b0, CTRL_OFS, 32'h0, q);
    chk(q[6], 1'b0);
    bus(1'b1, STATUS_OFS, 32'h1, q);
    bus(1'b0, STATUS_OFS, 32'h0, q);
    chk(q[ST_DRAINED], 1'b0);
    // streaming with valid on the frame pin, then an underrun
    bus(1'b1, CTRL_OFS, {20'h0, MODE_STREAM, 8'h63}, q);
    for (int n = 0; n < 300 && frameStrobeOut !== 1'b1; n++)
      @(posedge sys_clk);
    chk(frameStrobeOut, 1'b1);
    srcOn <= 1'b0;
    for (int n = 0; n < 300 && frameStrobeOut !== 1'b0; n++)
      @(posedge sys_clk);
    chk(frameStrobeOut, 1'b0);
    bus(1'b0, STATUS_OFS, 32'h0, q);
    chk(q[ST_BWERR], 1'b1);
    // short master frame: 6 lines of 20 bytes, field 2 from line 4
    bus(1'b1, FRAME_OFS, 32'h0002_0006, q);
    bus(1'b1, LINE_OFS, 32'h000c_0014, q);
    bus(1'b1, FIELD_OFS, 32'h0000_0004, q);
    bus(1'b1, VACT_OFS, 32'h0005_0002, q);
    bus(1'b1, CTRL_OFS, 32'h0000_0007, q);
    for (int n = 0; n < 2000 && frameStrobeOut !== 1'b1; n++)
      @(posedge sys_clk);
    chk(frameStrobeOut, 1'b1);
    // field pin stays high longer than one line
    repeat (200) @(posedge sys_clk);
    chk(frameStrobeOut, 1'b1);
    for (int n = 0; n < 2000 && frameStrobeOut !== 1'b0; n++)
      @(posedge sys_clk);
    chk(frameStrobeOut, 1'b0);
    for (int n = 0; n < 2000 && pixReq !== 1'b1; n++) @(posedge sys_clk);
    chk(pixReq, 1'b1);
    for (int n = 0; n < 2000 && chromaLineStep !== 1'b1; n++)
      @(posedge sys_clk);
    chk(chromaLineStep, 1'b1);
    for (int n = 0; n < 2000 && videoByteBus !== 8'h5a; n++)
      @(posedge sys_clk);
    chk(videoByteBus, 8'h5a);
    // one link clock later the v byte of the same group follows
    repeat (10) @(posedge sys_clk);
    chk(videoByteBus, 8'h66);
    // genlock on the encoder pulse, delay one line minus one clock
    bus(1'b1, SLVDLY_OFS, 32'h0000_0013, q);
    bus(1'b1, CTRL_OFS, 32'h0000_001a, q);
    repeat (2500) @(posedge sys_clk);
    bus(1'b0, STATUS_OFS, 32'h0, qOld);
    // one encoder frame later: agreeing edges leave the count alone
    repeat (960) @(posedge sys_clk);
    bus(1'b0, STATUS_OFS, 32'h0, q);
    chk(q[ST_LOCKED], 1'b1);
    chk(q[7:4], qOld[7:4]);
    chk(frameStrobeOeN, 1'b1);
    // second reset in mid-run
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(frameStrobeOeN, 1'b0);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    bus(1'b0, CTRL_OFS, 32'h0, q);
    chk(q, CTRL_RESET);
    end_of_test;
  end
endmodule
`default_nettype wire
